// >>> sbdcp_defines.svh
// shared constants of the serial binary analog-output command parser
// assumes a 200 MHz system clock on both ends
`ifndef SBDCP_DEFINES_SVH
`define SBDCP_DEFINES_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SBDCP_CLK_PERIOD_PS 5000
`define SBDCP_CHAR_TIME_NS 1040000
`define SBDCP_CHAR_CYCLES ((`SBDCP_CHAR_TIME_NS * 1000) / `SBDCP_CLK_PERIOD_PS)
`define SBDCP_INTEG_TIME_MS 200
`define SBDCP_INTEG_CYCLES ((`SBDCP_INTEG_TIME_MS * 1000000) / (`SBDCP_CLK_PERIOD_PS / 1000))
// ----------------------------------------------------------------
// characters and frame layout
// ----------------------------------------------------------------
`define SBDCP_CH_TILDE 8'h7E
`define SBDCP_CH_SUSPEND 8'h24
`define SBDCP_CH_CR 8'h0D
`define SBDCP_CH_READ_HDR 8'h5E
`define SBDCP_PAYLOAD_CHARS 3'h4
`define SBDCP_FRAME_MAX 3'h7
`define SBDCP_DAC_FULL 17'h0C350
`define SBDCP_MOD64_MASK 8'h3F
`endif

// >>> sbdcp_pkg.sv
// types and character helpers shared by both ends of the link
// assumes sbdcp_defines.svh is on the include path
`default_nettype none
package sbdcp_pkg;
   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   // analog control selection
   typedef enum logic [1:0] {
      SBDCP_SEL_LOCAL = 2'h0,
      SBDCP_SEL_HOST = 2'h1,
      SBDCP_SEL_DEVICE = 2'h2
   } sbdcp_sel_t;
   // analog write enable command kinds
   typedef enum logic [1:0] {
      SBDCP_EN_OFF = 2'h0,
      SBDCP_EN_ONESHOT = 2'h1,
      SBDCP_EN_PERSIST = 2'h2,
      SBDCP_EN_PERSIST_CKS = 2'h3
   } sbdcp_en_t;
   // receive state of the binary frame decoder
   typedef enum logic [1:0] {
      SBDCP_RX_IDLE = 2'h0,
      SBDCP_RX_BODY = 2'h1,
      SBDCP_RX_DROP = 2'h2
   } sbdcp_rx_t;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // payload char: parity in bit 7, bit 6 set, group in bits 5..0
   function automatic logic [7:0] sbdcp_enc(input logic [5:0] grp, input logic odd);
      sbdcp_enc = {(^{1'b1, grp}) ^ odd, 1'b1, grp};
   endfunction
   // parity check of a received payload char
   function automatic logic sbdcp_par_ok(input logic [7:0] ch, input logic odd);
      sbdcp_par_ok = ((^ch) == odd);
   endfunction
endpackage : sbdcp_pkg
`default_nettype wire

// >>> sbdcp_link_if.sv
// character-level serial link between the host and the transducer
// assumes both ends run on one clock; one char per valid cycle
`default_nettype none
interface sbdcp_link_if;
   // host to device characters
   logic h2d_valid;
   logic [7:0] h2d_char;
   // host analog write enable commands
   logic en_valid;
   logic [1:0] en_kind;
   // device to host characters
   logic d2h_valid;
   logic [7:0] d2h_char;
   // ----------------------------------------------------------------
   // modports
   // ----------------------------------------------------------------
   modport dev (input h2d_valid, h2d_char, en_valid, en_kind, output d2h_valid, d2h_char);
   modport host (output h2d_valid, h2d_char, en_valid, en_kind, input d2h_valid, d2h_char);
endinterface : sbdcp_link_if
`default_nettype wire

// >>> sbdcp_host.sv
// host end: encodes binary analog-output frames and control chars
// assumes the device accepts one char per cycle without stalling
`include "sbdcp_defines.svh"
`default_nettype none
module sbdcp_host
   import sbdcp_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // link
   sbdcp_link_if.host link,
   // frame request
   input wire logic send_dac_in,
   input wire logic [6:0] dac_addr_in,
   input wire logic [16:0] dac_value_in,
   input wire logic use_cks_in,
   input wire logic parity_odd_in,
   // control chars and enables
   input wire logic send_suspend_in,
   input wire logic send_cr_in,
   input wire logic en_send_in,
   input wire logic [1:0] en_kind_in,
   // status and receive
   output logic busy_out,
   output logic rx_valid_out,
   output logic [7:0] rx_char_out
);
   logic [7:0] buf_reg [0:6]; // frame chars in send order
   logic [2:0] len_reg; // chars in frame
   logic [2:0] idx_reg; // next char to send
   logic busy_reg; // frame in progress
   logic [7:0] out_char_reg; // char on the link
   logic out_valid_reg; // char strobe
   logic en_valid_reg; // enable strobe
   logic [1:0] en_kind_reg; // enable kind
   logic [23:0] bits; // address then value
   logic [7:0] p [0:3]; // encoded payload chars
   logic [7:0] sum; // carry-free sum low bits
   // ----------------------------------------------------------------
   // encoder
   // ----------------------------------------------------------------
   // split msb first into four groups, bit 6 forced high
   always_comb begin
      bits = {dac_addr_in, dac_value_in};
      p[0] = sbdcp_enc(bits[23:18], parity_odd_in);
      p[1] = sbdcp_enc(bits[17:12], parity_odd_in);
      p[2] = sbdcp_enc(bits[11:6], parity_odd_in);
      p[3] = sbdcp_enc(bits[5:0], parity_odd_in);
      sum = `SBDCP_CH_TILDE + p[0] + p[1] + p[2] + p[3];
   end
   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   // load frame on request, then one char per cycle
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         busy_reg <= 1'b0;
         len_reg <= 3'h0;
         idx_reg <= 3'h0;
         out_valid_reg <= 1'b0;
         out_char_reg <= 8'h00;
         for (int i = 0; i < 7; i++) begin
            buf_reg[i] <= 8'h00;
         end
      end else begin
         out_valid_reg <= 1'b0;
         if (busy_reg) begin
            out_valid_reg <= 1'b1;
            out_char_reg <= buf_reg[idx_reg];
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == len_reg - 3'h1) begin
               busy_reg <= 1'b0;
            end
         end else if (send_dac_in) begin
            buf_reg[0] <= `SBDCP_CH_TILDE;
            for (int i = 0; i < 4; i++) begin
               buf_reg[i + 1] <= p[i];
            end
            if (use_cks_in) begin
               buf_reg[5] <= sbdcp_enc(6'(8'h00 - sum), parity_odd_in);
               buf_reg[6] <= `SBDCP_CH_CR;
               len_reg <= `SBDCP_FRAME_MAX;
            end else begin
               buf_reg[5] <= `SBDCP_CH_CR;
               len_reg <= `SBDCP_FRAME_MAX - 3'h1;
            end
            idx_reg <= 3'h0;
            busy_reg <= 1'b1;
         end else if (send_suspend_in) begin
            out_valid_reg <= 1'b1;
            out_char_reg <= `SBDCP_CH_SUSPEND;
         end else if (send_cr_in) begin
            out_valid_reg <= 1'b1;
            out_char_reg <= `SBDCP_CH_CR;
         end
      end
   end
   // enable command strobe, sent ahead of frames by the user
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         en_valid_reg <= 1'b0;
         en_kind_reg <= 2'h0;
      end else begin
         en_valid_reg <= en_send_in;
         en_kind_reg <= en_kind_in;
      end
   end
   // register the device's chars for the user
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rx_valid_out <= 1'b0;
         rx_char_out <= 8'h00;
      end else begin
         rx_valid_out <= link.d2h_valid;
         rx_char_out <= link.d2h_char;
      end
   end
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.h2d_valid = out_valid_reg;
   assign link.h2d_char = out_char_reg;
   assign link.en_valid = en_valid_reg;
   assign link.en_kind = en_kind_reg;
   assign busy_out = busy_reg;
endmodule : sbdcp_host
`default_nettype wire

// >>> sbdcp_device.sv
// device end: suspend handling, binary frame decoder, reply sender
// assumes one host char per valid cycle; reading data from the sensor
`include "sbdcp_defines.svh"
`default_nettype none
module sbdcp_device
   import sbdcp_pkg::*;
#(
   parameter int CHAR_CYCLES = `SBDCP_CHAR_CYCLES,
   parameter int INTEG_CYCLES = `SBDCP_INTEG_CYCLES
)
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // link
   sbdcp_link_if.dev link,
   // configuration
   input wire logic parity_odd_in,
   input wire logic [1:0] control_sel_in,
   input wire logic [6:0] own_addr_in,
   input wire logic [6:0] group_addr_in,
   input wire logic reply_cks_in,
   input wire logic [27:0] integ_cycles_in,
   // reading commands
   input wire logic single_read_in,
   input wire logic cont_read_in,
   input wire logic binary_in,
   // measurement
   input wire logic [23:0] reading_in,
   input wire logic [16:0] dac_source_in,
   // status
   output logic suspended_out,
   output logic reading_tick_out,
   output logic reading_dropped_out,
   output logic dac_load_out,
   output logic [16:0] dac_value_out,
   output logic frame_error_out
);
   sbdcp_rx_t rx_state_reg; // decoder state
   logic [7:0] rx_buf_reg [0:5]; // received chars after the tilde
   logic [2:0] rx_cnt_reg; // chars received after the tilde
   logic [7:0] rx_sum_reg; // running carry-free sum
   logic suspend_reg; // readings held back
   logic oneshot_reg; // one frame allowed
   logic persist_reg; // frames allowed
   logic cks_req_reg; // checksum mandatory
   logic [27:0] integ_cnt_reg; // integration timer
   logic integ_run_reg; // timer running
   logic tick_reg; // reading ready pulse
   logic drop_reg; // reading discarded pulse
   logic load_reg; // analog output updated pulse
   logic [16:0] dac_reg; // analog output value
   logic err_reg; // frame rejected pulse
   logic [7:0] tx_buf_reg [0:6]; // outgoing frame
   logic [2:0] tx_len_reg; // chars in outgoing frame
   logic [2:0] tx_idx_reg; // next char to send
   logic tx_busy_reg; // frame going out
   logic dac_pend_reg; // analog frame follows reading
   logic [17:0] char_cnt_reg; // char time pacer
   logic d2h_valid_reg; // char strobe
   logic [7:0] d2h_char_reg; // char on the link
   logic [27:0] integ_len; // effective integration length
   logic [23:0] rx_bits; // decoded payload
   logic rx_par_ok; // all payload parities good
   logic rx_done; // carriage return closing a frame
   logic rx_has_cks; // frame carried a checksum
   logic rx_good; // frame accepted
   logic [7:0] rx_sum_next; // sum including this char
   logic want_cks; // checksum on sent frames
   // ----------------------------------------------------------------
   // suspend control
   // ----------------------------------------------------------------
   // suspend char while continuous output runs; any return resumes
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         suspend_reg <= 1'b0;
      end else if (!cont_read_in) begin
         suspend_reg <= 1'b0;
      end else if (link.h2d_valid && link.h2d_char == `SBDCP_CH_SUSPEND
            && rx_state_reg == SBDCP_RX_IDLE) begin
         suspend_reg <= 1'b1;
      end else if (link.h2d_valid && link.h2d_char == `SBDCP_CH_CR) begin
         suspend_reg <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // write enable state
   // ----------------------------------------------------------------
   // enable commands; the oneshot is spent by any frame end except the return of an overlong frame
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         oneshot_reg <= 1'b0;
         persist_reg <= 1'b0;
         cks_req_reg <= 1'b0;
      end else if (link.en_valid) begin
         oneshot_reg <= (link.en_kind == SBDCP_EN_ONESHOT);
         persist_reg <= (link.en_kind == SBDCP_EN_PERSIST) || (link.en_kind == SBDCP_EN_PERSIST_CKS);
         cks_req_reg <= (link.en_kind == SBDCP_EN_PERSIST_CKS);
      end else if (rx_done) begin
         oneshot_reg <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // frame decoder
   // ----------------------------------------------------------------
   // checks of the collected frame at its closing return
   always_comb begin
      rx_sum_next = rx_sum_reg + link.h2d_char;
      rx_bits = {rx_buf_reg[0][5:0], rx_buf_reg[1][5:0], rx_buf_reg[2][5:0], rx_buf_reg[3][5:0]};
      rx_par_ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rx_par_ok = rx_par_ok && sbdcp_par_ok(rx_buf_reg[i], parity_odd_in);
      end
      rx_has_cks = (rx_cnt_reg == `SBDCP_PAYLOAD_CHARS + 3'h1);
      if (rx_has_cks) begin
         rx_par_ok = rx_par_ok && sbdcp_par_ok(rx_buf_reg[4], parity_odd_in);
      end
      rx_done = (rx_state_reg == SBDCP_RX_BODY) && link.h2d_valid && link.h2d_char == `SBDCP_CH_CR;
      rx_good = rx_done && rx_par_ok
         && (rx_cnt_reg == `SBDCP_PAYLOAD_CHARS || rx_has_cks)
         && (!rx_has_cks || (rx_sum_reg & `SBDCP_MOD64_MASK) == 8'h00)
         && (!cks_req_reg || rx_has_cks)
         && (oneshot_reg || persist_reg)
         && control_sel_in == SBDCP_SEL_HOST
         && rx_bits[23:17] == own_addr_in;
   end
   // collect chars between tilde and return
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rx_state_reg <= SBDCP_RX_IDLE;
         rx_cnt_reg <= 3'h0;
         rx_sum_reg <= 8'h00;
         for (int i = 0; i < 6; i++) begin
            rx_buf_reg[i] <= 8'h00;
         end
      end else if (link.h2d_valid) begin
         case (rx_state_reg)
            SBDCP_RX_IDLE: begin
               // header starts a frame
               if (link.h2d_char == `SBDCP_CH_TILDE) begin
                  rx_state_reg <= SBDCP_RX_BODY;
                  rx_cnt_reg <= 3'h0;
                  rx_sum_reg <= `SBDCP_CH_TILDE;
               end
            end
            SBDCP_RX_BODY: begin
               // store payload and checksum chars
               if (link.h2d_char == `SBDCP_CH_CR) begin
                  rx_state_reg <= SBDCP_RX_IDLE;
               end else if (rx_cnt_reg == `SBDCP_PAYLOAD_CHARS + 3'h1) begin
                  rx_state_reg <= SBDCP_RX_DROP; // too long
               end else begin
                  rx_buf_reg[rx_cnt_reg] <= link.h2d_char;
                  rx_cnt_reg <= rx_cnt_reg + 3'h1;
                  rx_sum_reg <= rx_sum_next;
               end
            end
            SBDCP_RX_DROP: begin
               // wait for the return of an overlong frame
               if (link.h2d_char == `SBDCP_CH_CR) begin
                  rx_state_reg <= SBDCP_RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= SBDCP_RX_IDLE;
            end
         endcase
      end
   end
   // analog output update, clamped to full scale
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         dac_reg <= 17'h00000;
         load_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         load_reg <= rx_good;
         err_reg <= rx_done && !rx_good;
         if (rx_good) begin
            dac_reg <= (rx_bits[16:0] > `SBDCP_DAC_FULL) ? `SBDCP_DAC_FULL : rx_bits[16:0];
         end
      end
   end
   // ----------------------------------------------------------------
   // integration timer
   // ----------------------------------------------------------------
   assign integ_len = (integ_cycles_in == 28'h0000000) ? 28'(INTEG_CYCLES) : integ_cycles_in;
   // one reading per integration period; single read stops after one
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         integ_cnt_reg <= 28'h0000000;
         integ_run_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (!integ_run_reg) begin
            if (single_read_in || cont_read_in) begin
               integ_run_reg <= 1'b1;
               integ_cnt_reg <= integ_len - 28'h1;
            end
         end else if (integ_cnt_reg == 28'h0000000) begin
            tick_reg <= 1'b1;
            integ_run_reg <= cont_read_in;
            integ_cnt_reg <= integ_len - 28'h1;
         end else begin
            integ_cnt_reg <= integ_cnt_reg - 28'h1;
         end
      end
   end
   // ----------------------------------------------------------------
   // reply sender
   // ----------------------------------------------------------------
   assign want_cks = reply_cks_in || cks_req_reg;
   // build reading and analog frames, paced one char per char time
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tx_busy_reg <= 1'b0;
         tx_len_reg <= 3'h0;
         tx_idx_reg <= 3'h0;
         dac_pend_reg <= 1'b0;
         char_cnt_reg <= 18'h00000;
         drop_reg <= 1'b0;
         d2h_valid_reg <= 1'b0;
         d2h_char_reg <= 8'h00;
         for (int i = 0; i < 7; i++) begin
            tx_buf_reg[i] <= 8'h00;
         end
      end else begin
         d2h_valid_reg <= 1'b0;
         drop_reg <= tick_reg && (suspend_reg || tx_busy_reg || dac_pend_reg || !binary_in);
         // pacer also runs between frames
         if (char_cnt_reg != 18'h00000) begin
            char_cnt_reg <= char_cnt_reg - 18'h1;
         end
         if (tx_busy_reg) begin
            // char time is a fixed count, parity never lengthens it
            if (char_cnt_reg == 18'h00000) begin
               d2h_valid_reg <= 1'b1;
               d2h_char_reg <= tx_buf_reg[tx_idx_reg];
               tx_idx_reg <= tx_idx_reg + 3'h1;
               char_cnt_reg <= 18'(CHAR_CYCLES - 1);
               if (tx_idx_reg == tx_len_reg - 3'h1) begin
                  tx_busy_reg <= 1'b0;
               end
            end
         end else if ((tick_reg && binary_in && !suspend_reg) || dac_pend_reg) begin
            tx_buf_reg[0] <= dac_pend_reg ? `SBDCP_CH_TILDE : `SBDCP_CH_READ_HDR;
            for (int i = 0; i < 4; i++) begin
               tx_buf_reg[i + 1] <= sbdcp_enc(dac_pend_reg
                  ? 6'({group_addr_in, dac_source_in} >> (18 - 6 * i))
                  : 6'(reading_in >> (18 - 6 * i)), parity_odd_in);
            end
            if (want_cks) begin
               tx_buf_reg[5] <= sbdcp_enc(6'(8'h00 - (dac_pend_reg ? `SBDCP_CH_TILDE : `SBDCP_CH_READ_HDR)
                  - sbdcp_enc(dac_pend_reg ? group_addr_in[6:1] : reading_in[23:18], parity_odd_in)
                  - sbdcp_enc(dac_pend_reg ? {group_addr_in[0], dac_source_in[16:12]} : reading_in[17:12],
                     parity_odd_in)
                  - sbdcp_enc(dac_pend_reg ? dac_source_in[11:6] : reading_in[11:6], parity_odd_in)
                  - sbdcp_enc(dac_pend_reg ? dac_source_in[5:0] : reading_in[5:0], parity_odd_in)), parity_odd_in);
               tx_buf_reg[6] <= `SBDCP_CH_CR;
               tx_len_reg <= `SBDCP_FRAME_MAX;
            end else begin
               tx_buf_reg[5] <= `SBDCP_CH_CR;
               tx_len_reg <= `SBDCP_FRAME_MAX - 3'h1;
            end
            tx_idx_reg <= 3'h0;
            tx_busy_reg <= 1'b1;
            dac_pend_reg <= !dac_pend_reg && control_sel_in == SBDCP_SEL_DEVICE;
         end
      end
   end
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.d2h_valid = d2h_valid_reg;
   assign link.d2h_char = d2h_char_reg;
   assign suspended_out = suspend_reg;
   assign reading_tick_out = tick_reg;
   assign reading_dropped_out = drop_reg;
   assign dac_load_out = load_reg;
   assign dac_value_out = dac_reg;
   assign frame_error_out = err_reg;
endmodule : sbdcp_device
`default_nettype wire

// >>> sbdcp_monitor.sv
// link checker of the host/device pair of the command parser
// assumes CHAR_CYCLES is the device's char spacing and is at least 4
`default_nettype none
module sbdcp_monitor #(
   parameter int CHAR_CYCLES = 4
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // host to device
   input wire logic h2d_valid,
   input wire logic [7:0] h2d_char,
   input wire logic en_valid,
   input wire logic [1:0] en_kind,
   // device to host
   input wire logic d2h_valid,
   input wire logic [7:0] d2h_char
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic [2:0] n_reg; // reply chars seen since header
   wire logic tilde = h2d_valid && h2d_char == 8'h7E; // frame header
   wire logic rhdr = d2h_valid && d2h_char == 8'h5E; // reading header
   // ----------------------------------------------------------------
   // reply length counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         n_reg <= 3'h0;
      else if (rhdr || (d2h_valid && d2h_char == 8'h7E))
         n_reg <= 3'h1;
      else if (d2h_valid)
         n_reg <= n_reg + 3'h1;
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_payload_back_to_back: assert property (tilde |=> h2d_valid [*4])
      else $error("payload chars not back to back");
   chk_payload_bit_six: assert property (tilde |=> h2d_char[6] [*4])
      else $error("payload bit 6 clear");
   chk_frame_cr_close: assert property (tilde |-> ##[5:6] (h2d_valid && h2d_char == 8'h0D))
      else $error("frame not closed by return");
   chk_reply_char_gap: assert property (d2h_valid |=> !d2h_valid [*3])
      else $error("reply chars too close");
   chk_reply_next_char: assert property (rhdr |-> ##CHAR_CYCLES d2h_valid)
      else $error("reply char late");
   chk_reply_payload_six: assert property (rhdr |-> ##CHAR_CYCLES d2h_char[6])
      else $error("reply payload bit 6 clear");
   chk_reply_length: assert property (d2h_valid && d2h_char == 8'h0D |-> n_reg == 3'h5 || n_reg == 3'h6)
      else $error("reply length wrong");
   chk_enable_pulse: assert property (en_valid |=> !en_valid)
      else $error("enable strobe too long");
   // main scenarios
   cover property (tilde);
   cover property (rhdr);
   cover property (h2d_valid && h2d_char == 8'h24);
endmodule // sbdcp_monitor
`default_nettype wire

// >>> sbdcp_test.sv
// self-checking bench: host and device joined over the link
// assumes the device runs with CHAR_CYCLES 4 and INTEG_CYCLES 20
`default_nettype none
module sbdcp_test import sbdcp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic sd = 1'b0, sus = 1'b0, scr = 1'b0, ens = 1'b0, cks = 1'b0, hodd = 1'b0, dodd = 1'b0, cont = 1'b0;
   logic srd = 1'b0, rcks = 1'b0, bin = 1'b1;
   logic [1:0] ek = 2'h0, sel = 2'h1;
   logic [6:0] adr = 7'h00, own = 7'h07;
   logic [16:0] val = 17'h00000, dsrc = 17'h0C350;
   logic [23:0] rd = 24'h041041;
   logic busy, rxv, dl, fe, susp, tick, drop, done;
   logic [7:0] rxc;
   logic [16:0] dv;
   logic [7:0] er [6] = '{8'h5E, 8'h41, 8'h41, 8'h41, 8'h41, 8'h0D}; // expected reading reply
   int n_fail = 0;
   int n_tests = 0;
   always #2.5 clock_in = ~clock_in;
   always_comb done = dl | fe;
   sbdcp_link_if link ();
   sbdcp_host i_sbdcp_host (.clock_in(clock_in), .rst_in(rst_in), .link(link), .send_dac_in(sd), .dac_addr_in(adr),
      .dac_value_in(val), .use_cks_in(cks), .parity_odd_in(hodd), .send_suspend_in(sus), .send_cr_in(scr),
      .en_send_in(ens), .en_kind_in(ek), .busy_out(busy), .rx_valid_out(rxv), .rx_char_out(rxc));
   sbdcp_device #(.CHAR_CYCLES(4), .INTEG_CYCLES(20)) i_sbdcp_device (.clock_in(clock_in), .rst_in(rst_in),
      .link(link), .parity_odd_in(dodd), .control_sel_in(sel), .own_addr_in(own), .group_addr_in(7'h09),
      .reply_cks_in(rcks), .integ_cycles_in(28'h0000064), .single_read_in(srd), .cont_read_in(cont),
      .binary_in(bin), .reading_in(rd), .dac_source_in(dsrc), .suspended_out(susp),
      .reading_tick_out(tick), .reading_dropped_out(drop), .dac_load_out(dl), .dac_value_out(dv),
      .frame_error_out(fe));
   sbdcp_monitor #(.CHAR_CYCLES(4)) i_sbdcp_monitor (.clock_in(clock_in), .rst_in(rst_in),
      .h2d_valid(link.h2d_valid), .h2d_char(link.h2d_char), .en_valid(link.en_valid), .en_kind(link.en_kind),
      .d2h_valid(link.d2h_valid), .d2h_char(link.d2h_char));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // compare one value
   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // bounded wait for a flag
   task automatic wt(ref logic s, input int n);
      repeat (n) begin
         @(posedge clock_in);
         #1;
         if (s === 1'b1) return;
      end
      chk("wait", 17'h00001, 17'h00000);
   endtask
   // send one frame, expect load or refusal
   task automatic frame(input logic [6:0] a, input logic [16:0] v, input logic c, input logic ok, input logic [16:0] e);
      @(posedge clock_in);
      sd <= 1'b1;
      adr <= a;
      val <= v;
      cks <= c;
      @(posedge clock_in);
      sd <= 1'b0;
      wt(done, 20);
      chk("load", {16'h0000, ok}, {16'h0000, dl});
      chk("value", e, dv);
   endtask
   // issue an enable command
   task automatic en(input logic [1:0] k);
      @(posedge clock_in);
      ens <= 1'b1;
      ek <= k;
      @(posedge clock_in);
      ens <= 1'b0;
      repeat (2) @(posedge clock_in);
   endtask
   // send return (1) or suspend (0)
   task automatic ctl(input logic c);
      @(posedge clock_in);
      scr <= c;
      sus <= !c;
      @(posedge clock_in);
      scr <= 1'b0;
      sus <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
   endtask
   // verdict and end of run
   task automatic close_out;
      if (n_fail == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      #20us;
      n_fail++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clock_in);
      rst_in <= 1'b0;
      frame(7'h07, 17'h0A604, 1'b0, 1'b0, 17'h00000);
      en(SBDCP_EN_ONESHOT);
      frame(7'h07, 17'h0A604, 1'b0, 1'b1, 17'h0A604);
      frame(7'h07, 17'h00064, 1'b0, 1'b0, 17'h0A604);
      en(SBDCP_EN_PERSIST);
      frame(7'h07, 17'h061A8, 1'b1, 1'b1, 17'h061A8);
      frame(7'h07, 17'h0EA60, 1'b0, 1'b1, 17'h0C350);
      frame(7'h08, 17'h00064, 1'b0, 1'b0, 17'h0C350);
      dodd <= 1'b1;
      frame(7'h07, 17'h00064, 1'b0, 1'b0, 17'h0C350);
      hodd <= 1'b1;
      frame(7'h07, 17'h00064, 1'b0, 1'b1, 17'h00064);
      dodd <= 1'b0;
      hodd <= 1'b0;
      sel <= 2'h0;
      frame(7'h07, 17'h000C8, 1'b0, 1'b0, 17'h00064);
      sel <= 2'h1;
      en(SBDCP_EN_PERSIST_CKS);
      frame(7'h07, 17'h0012C, 1'b0, 1'b0, 17'h00064);
      frame(7'h07, 17'h0012C, 1'b1, 1'b1, 17'h0012C);
      en(SBDCP_EN_OFF);
      frame(7'h07, 17'h000C8, 1'b0, 1'b0, 17'h0012C);
      srd <= 1'b1;
      @(posedge clock_in);
      srd <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wt(rxv, 300);
         chk("reply", {9'h000, er[i]}, {9'h000, rxc});
      end
      cont <= 1'b1;
      ctl(1'b0);
      chk("suspended", 17'h00001, {16'h0000, susp});
      wt(tick, 300);
      @(posedge clock_in);
      #1;
      chk("dropped", 17'h00001, {16'h0000, drop});
      rcks <= 1'b1;
      ctl(1'b1);
      chk("suspended", 17'h00000, {16'h0000, susp});
      wt(rxv, 300);
      chk("resume", 17'h0005E, {9'h000, rxc});
      repeat (5) wt(rxv, 10);
      chk("reply cks", 17'h000DE, {9'h000, rxc});
      wt(rxv, 10);
      chk("reply end", 17'h0000D, {9'h000, rxc});
      bin <= 1'b0;
      wt(tick, 300);
      @(posedge clock_in);
      #1;
      chk("dropped", 17'h00001, {16'h0000, drop});
      bin <= 1'b1;
      sel <= 2'h2;
      repeat (8) wt(rxv, 300);
      chk("dev frame", 17'h0007E, {9'h000, rxc});
      wt(rxv, 10);
      chk("group", 17'h00044, {9'h000, rxc});
      wt(rxv, 10);
      chk("dev value", 17'h0006C, {9'h000, rxc});
      close_out();
   end
endmodule // sbdcp_test
`default_nettype wire
